//--- verilog/brtc_consts.svh
`ifndef BRTC_CONSTS_SVH
`define BRTC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define BRTC_REG_CNT0 3'h0
`define BRTC_REG_CNT3 3'h3
`define BRTC_REG_CTRL 3'h4
`define BRTC_REG_CHG 3'h5
`define BRTC_REG_LAST 3'h5
`define BRTC_PTR_FIRST 3'h0

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define BRTC_CTRL_STOP_BIT 7
`define BRTC_CTRL_RESET 1'b0
`define BRTC_CHG_RESET 8'h00
`define BRTC_CNT_RESET 32'h0000_0000
`define BRTC_CHG_ENABLE_PAT 4'hA
`define BRTC_DIODE_NONE 2'h1
`define BRTC_DIODE_ONE 2'h2
`define BRTC_RES_OFF 2'h0
`define BRTC_BYTE_BITS 4'h8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BRTC_CORE_HZ 40000000
`define BRTC_TICK_DIV 32768
`define BRTC_RELEASE_MS 250
`define BRTC_OSC_START_MS 1000

`endif

//--- verilog/brtc_pkg.sv
package brtc_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [5:0] {
      SER_IDLE = 6'h01,
      SER_ADDR = 6'h02,
      SER_WRITE = 6'h04,
      SER_ACK = 6'h08,
      SER_READ = 6'h10,
      SER_RACK = 6'h20
   } brtc_ser_state_t;

   typedef enum logic [2:0] {
      PWR_FAIL = 3'h1,
      PWR_HOLD = 3'h2,
      PWR_RUN = 3'h4
   } brtc_pwr_state_t;

   typedef struct packed {
      logic [3:0] chargerEnablePattern;
      logic [1:0] diodeSelect;
      logic [1:0] resistorSelect;
   } brtc_charge_cfg_t;

endpackage : brtc_pkg

//--- verilog/brtc_sync.sv
`timescale 1ns/100ps
module brtc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule : brtc_sync

//--- verilog/brtc_tick.sv
`timescale 1ns/100ps
`include "brtc_consts.svh"
module brtc_tick #(
   parameter int DIV = `BRTC_TICK_DIV
) (
   // Oscillator clock and reset
   input wire logic oscIn,
   input wire logic rst_n,
   // Second event, flips once per second
   output logic tickToggle
);

   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] divCnt_q;

   // A toggle rather than a pulse, so the slow domain event survives the crossing.
   always_ff @(posedge oscIn or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_q <= '0;
         tickToggle <= 1'b0;
      end else if (divCnt_q == LAST) begin
         divCnt_q <= '0;
         tickToggle <= ~tickToggle;
      end else begin
         divCnt_q <= divCnt_q + W'(1);
      end
   end

   AST_TICK_PERIOD: assert property (@(posedge oscIn) disable iff (!rst_n)
      (divCnt_q != LAST) |=> (tickToggle == $past(tickToggle)))
      else $error("Tick toggled before the full oscillator count.");

endmodule : brtc_tick

//--- verilog/brtc_top.sv
`timescale 1ns/100ps
`include "brtc_consts.svh"
module brtc_top #(
   parameter logic [6:0] DEV_ID = 7'h5A, // Arbitrary value.
   parameter int TICK_DIV = `BRTC_TICK_DIV,
   parameter int RELEASE_CYC = `BRTC_RELEASE_MS * (`BRTC_CORE_HZ / 1000),
   parameter int OSC_START_CYC = `BRTC_OSC_START_MS * (`BRTC_CORE_HZ / 1000)
) (
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Oscillator clock
   input wire logic oscIn,
   output logic oscRunEn,
   // Serial bus pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Supply monitor
   input wire logic vccBelowFailThreshold,
   input wire logic vccBelowBackupSupply,
   output logic onBackupSupply,
   output logic sysRstOut,
   output logic sysRstOe,
   // Trickle charger
   output brtc_pkg::brtc_charge_cfg_t chargerCfg,
   output logic chargerEnable
);

   // -------------------------------------------------------------------------
   // Synchronisers and event detection
   // -------------------------------------------------------------------------
   logic tickToggle;
   logic [4:0] syncQ;
   logic sclS, sdaS, pwrFailS, belowBackupS, tickS;
   logic sclD_q, sdaD_q, tickD_q;
   logic sclRise, sclFall, startEv, stopEv, tickEv;

   brtc_tick #(.DIV(TICK_DIV)) u_tick (.oscIn(oscIn), .rst_n(rst_n), .tickToggle(tickToggle));

   // Bus pins pass inverted, so the zero reset of the synchroniser matches the idle-high bus.
   brtc_sync #(
      .W(5)
   ) u_sync (
      .clk(core_clk),
      .rst_n(rst_n),
      .d({~scl, ~sdaIn, vccBelowFailThreshold, vccBelowBackupSupply, tickToggle}),
      .q(syncQ)
   );

   assign {sclS, sdaS, pwrFailS, belowBackupS, tickS} = {~syncQ[4], ~syncQ[3], syncQ[2:0]};

   // Idle bus levels are high, so the scl and sda delay flops reset high to avoid a false start.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclD_q <= 1'b1;
         sdaD_q <= 1'b1;
         tickD_q <= 1'b0;
      end else begin
         sclD_q <= sclS;
         sdaD_q <= sdaS;
         tickD_q <= tickS;
      end
   end

   assign sclRise = sclS & ~sclD_q;
   assign sclFall = ~sclS & sclD_q;
   assign startEv = sclS & sclD_q & sdaD_q & ~sdaS;
   assign stopEv = sclS & sclD_q & ~sdaD_q & sdaS;
   assign tickEv = tickS ^ tickD_q;

   // -------------------------------------------------------------------------
   // Supply monitor and reset release
   // -------------------------------------------------------------------------
   brtc_pkg::brtc_pwr_state_t pwr_q;
   logic [31:0] holdCnt_q, holdTarget;
   logic accessEn, stop_q;

   assign holdTarget = stop_q ? 32'(RELEASE_CYC + OSC_START_CYC) : 32'(RELEASE_CYC);
   // The fail input gates access directly, so no acknowledge starts in the cycle the state moves.
   assign accessEn = (pwr_q == brtc_pkg::PWR_RUN) && !pwrFailS;

   // Power-up is treated as a supply return, so the release delay also runs after reset.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q <= brtc_pkg::PWR_FAIL;
         holdCnt_q <= 32'h0000_0000;
      end else begin
         case (pwr_q)
            brtc_pkg::PWR_FAIL: begin
               holdCnt_q <= 32'h0000_0000;
               if (!pwrFailS) begin
                  pwr_q <= brtc_pkg::PWR_HOLD;
               end
            end
            brtc_pkg::PWR_HOLD: begin
               if (pwrFailS) begin
                  pwr_q <= brtc_pkg::PWR_FAIL;
               end else if (holdCnt_q >= holdTarget - 32'h0000_0001) begin
                  pwr_q <= brtc_pkg::PWR_RUN;
               end else begin
                  holdCnt_q <= holdCnt_q + 32'h0000_0001;
               end
            end
            brtc_pkg::PWR_RUN: begin
               if (pwrFailS) begin
                  pwr_q <= brtc_pkg::PWR_FAIL;
               end
            end
            default: begin
               pwr_q <= brtc_pkg::PWR_FAIL;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sysRstOe <= 1'b1;
         onBackupSupply <= 1'b0;
         oscRunEn <= 1'b1;
      end else begin
         sysRstOe <= pwrFailS | (pwr_q != brtc_pkg::PWR_RUN);
         onBackupSupply <= pwrFailS & belowBackupS;
         oscRunEn <= ~(pwrFailS & belowBackupS & stop_q);
      end
   end

   assign sysRstOut = 1'b0;
   assign sdaOut = 1'b0;

   // -------------------------------------------------------------------------
   // Serial slave
   // -------------------------------------------------------------------------
   brtc_pkg::brtc_ser_state_t ser_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q, rdByte;
   logic [2:0] ptr_q, nextPtr;
   logic gotPtr_q, isRead_q, regWr;
   logic [31:0] cnt_q, snap_q;
   brtc_pkg::brtc_charge_cfg_t chg_q;

   assign nextPtr = (ptr_q == `BRTC_REG_LAST) ? `BRTC_PTR_FIRST : ptr_q + 3'h1;
   assign regWr = accessEn && !stopEv && !startEv && (ser_q == brtc_pkg::SER_WRITE) && sclFall
      && (bitCnt_q == `BRTC_BYTE_BITS) && gotPtr_q;

   // Counter bytes come from a snapshot taken when a read is addressed.
   always_comb begin
      case (ptr_q)
         3'h0: rdByte = snap_q[7:0];
         3'h1: rdByte = snap_q[15:8];
         3'h2: rdByte = snap_q[23:16];
         3'h3: rdByte = snap_q[31:24];
         `BRTC_REG_CTRL: rdByte = {stop_q, 7'h00};
         `BRTC_REG_CHG: rdByte = chg_q;
         default: rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_q <= brtc_pkg::SER_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= `BRTC_PTR_FIRST;
         gotPtr_q <= 1'b0;
         isRead_q <= 1'b0;
         sdaOe <= 1'b0;
         snap_q <= `BRTC_CNT_RESET;
      end else if (!accessEn || stopEv) begin
         ser_q <= brtc_pkg::SER_IDLE;
         sdaOe <= 1'b0;
      end else if (startEv) begin
         ser_q <= brtc_pkg::SER_ADDR;
         bitCnt_q <= 4'h0;
         gotPtr_q <= 1'b0;
         sdaOe <= 1'b0;
      end else begin
         case (ser_q)
            brtc_pkg::SER_ADDR, brtc_pkg::SER_WRITE: begin
               if (sclRise) begin
                  shift_q <= {shift_q[6:0], sdaS};
                  bitCnt_q <= bitCnt_q + 4'h1;
               end else if (sclFall && bitCnt_q == `BRTC_BYTE_BITS) begin
                  if (ser_q == brtc_pkg::SER_ADDR) begin
                     if (shift_q[7:1] == DEV_ID) begin
                        sdaOe <= 1'b1;
                        isRead_q <= shift_q[0];
                        ser_q <= brtc_pkg::SER_ACK;
                        if (shift_q[0]) begin
                           snap_q <= cnt_q;
                        end
                     end else begin
                        ser_q <= brtc_pkg::SER_IDLE;
                     end
                  end else begin
                     sdaOe <= 1'b1;
                     ser_q <= brtc_pkg::SER_ACK;
                     if (!gotPtr_q) begin
                        gotPtr_q <= 1'b1;
                        ptr_q <= (shift_q > 8'(`BRTC_REG_LAST)) ? `BRTC_PTR_FIRST : shift_q[2:0];
                     end else begin
                        ptr_q <= nextPtr;
                     end
                  end
               end
            end
            brtc_pkg::SER_ACK, brtc_pkg::SER_RACK: begin
               if (ser_q == brtc_pkg::SER_RACK && sclRise && sdaS) begin
                  ser_q <= brtc_pkg::SER_IDLE;
               end else if (sclFall) begin
                  bitCnt_q <= 4'h0;
                  if (isRead_q) begin
                     shift_q <= rdByte;
                     sdaOe <= ~rdByte[7];
                     ptr_q <= nextPtr;
                     ser_q <= brtc_pkg::SER_READ;
                  end else begin
                     sdaOe <= 1'b0;
                     ser_q <= brtc_pkg::SER_WRITE;
                  end
               end
            end
            brtc_pkg::SER_READ: begin
               if (sclFall) begin
                  if (bitCnt_q == 4'h7) begin
                     sdaOe <= 1'b0;
                     ser_q <= brtc_pkg::SER_RACK;
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     sdaOe <= ~shift_q[6];
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
               end
            end
            brtc_pkg::SER_IDLE: begin
               sdaOe <= 1'b0;
            end
            default: begin
               ser_q <= brtc_pkg::SER_IDLE;
               sdaOe <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Seconds counter and control registers
   // -------------------------------------------------------------------------
   // A byte write wins over a tick in the same cycle; the whole word moves at once.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= `BRTC_CNT_RESET;
      end else if (regWr && ptr_q <= `BRTC_REG_CNT3) begin
         cnt_q[{ptr_q[1:0], 3'b000} +: 8] <= shift_q;
      end else if (tickEv && !stop_q) begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_q <= `BRTC_CTRL_RESET;
         chg_q <= `BRTC_CHG_RESET;
      end else if (regWr && ptr_q == `BRTC_REG_CTRL) begin
         stop_q <= shift_q[`BRTC_CTRL_STOP_BIT];
      end else if (regWr && ptr_q == `BRTC_REG_CHG) begin
         chg_q <= shift_q;
      end
   end

   // Reserved diode codes and the zero resistor code also keep the charger off.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chargerEnable <= 1'b0;
      end else begin
         chargerEnable <= (chg_q.chargerEnablePattern == `BRTC_CHG_ENABLE_PAT)
            && (chg_q.diodeSelect == `BRTC_DIODE_NONE || chg_q.diodeSelect == `BRTC_DIODE_ONE)
            && (chg_q.resistorSelect != `BRTC_RES_OFF);
      end
   end

   assign chargerCfg = chg_q;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   AST_PTR_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ptr_q == `BRTC_REG_LAST && ser_q == brtc_pkg::SER_RACK && sclFall && isRead_q)
      |=> (ptr_q == `BRTC_PTR_FIRST))
      else $error("Pointer did not wrap to zero.");
   AST_NO_ACK_IN_FAIL: assert property (@(posedge core_clk) disable iff (!rst_n)
      pwrFailS |=> !sdaOe && !regWr)
      else $error("Serial access active while supply failed.");
   AST_RST_IN_FAIL: assert property (@(posedge core_clk) disable iff (!rst_n)
      pwrFailS |=> sysRstOe)
      else $error("Reset not held while supply failed.");
   AST_RST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(pwrFailS) |-> sysRstOe [*8])
      else $error("Reset released too early after supply return.");
   AST_COUNT_INC: assert property (@(posedge core_clk) disable iff (!rst_n)
      (tickEv && !stop_q && !regWr) |=> (cnt_q == $past(cnt_q) + 32'h0000_0001))
      else $error("Counter did not advance on a tick.");
   AST_COUNT_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (stop_q && !regWr) |=> $stable(cnt_q))
      else $error("Counter moved while stopped.");
   AST_CHG_PATTERN: assert property (@(posedge core_clk) disable iff (!rst_n)
      chargerEnable |-> ($past(chg_q.chargerEnablePattern) == `BRTC_CHG_ENABLE_PAT))
      else $error("Charger enabled without the enable pattern.");
   AST_OSC_PRIMARY: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!pwrFailS) |=> oscRunEn)
      else $error("Oscillator stopped on primary supply.");
   AST_BACKUP_SRC: assert property (@(posedge core_clk) disable iff (!rst_n)
      onBackupSupply |-> $past(pwrFailS) && $past(belowBackupS))
      else $error("Backup selected while primary supply good.");

endmodule : brtc_top

//--- dv/brtc_i2c_master.sv
`timescale 1ns/100ps
module brtc_i2c_master #(
   parameter int QTR = 8
) (
   // Timing reference
   input wire logic core_clk,
   // Bus lines, a released line is pulled up
   input wire logic sdaLine,
   output logic scl,
   output logic sdaRel
);
   initial begin
      scl = 1'b1;
      sdaRel = 1'b1;
   end

   // Both lines move on a falling core edge and then hold for a quarter bit.
   task automatic lines(input logic c, input logic d);
      scl = c;
      sdaRel = d;
      repeat (QTR) @(negedge core_clk);
   endtask : lines

   // Data changes only while the clock is low, so only these two frame a transfer.
   task automatic start();
      lines(1'b0, 1'b1);
      lines(1'b1, 1'b1);
      lines(1'b1, 1'b0);
      lines(1'b0, 1'b0);
   endtask : start

   task automatic stop();
      lines(1'b0, 1'b0);
      lines(1'b1, 1'b0);
      lines(1'b1, 1'b1);
   endtask : stop

   task automatic clockBit(input logic b, output logic s);
      lines(1'b0, b);
      lines(1'b1, b);
      s = sdaLine;
      lines(1'b1, b);
      lines(1'b0, b);
   endtask : clockBit

   task automatic sendByte(input logic [7:0] b, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clockBit(b[i], s);
      end
      clockBit(1'b1, nack);
   endtask : sendByte

   // The last byte of a read is refused so that the device lets go of the line.
   task automatic recvByte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clockBit(1'b1, b[i]);
      end
      clockBit(last, s);
   endtask : recvByte
endmodule : brtc_i2c_master

//--- dv/tb.sv
`timescale 1ns/100ps
module tb;
   localparam logic [6:0] DEV_ID = 7'h3C; // Arbitrary value.
   localparam int TICK_DIV = 64;
   localparam int RELEASE_CYC = 40;
   localparam int OSC_START_CYC = 20;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic oscIn = 1'b0;
   logic vccBelowFailThreshold = 1'b0;
   logic vccBelowBackupSupply = 1'b0;
   logic scl, sdaRel, sdaLine, sdaOut, sdaOe, oscRunEn, onBackupSupply;
   logic sysRstOut, sysRstOe, sysRstLine, chargerEnable;
   brtc_pkg::brtc_charge_cfg_t chargerCfg;
   int n_fail = 0;
   int checked = 0;
   int oscCount = 0;

   always #12.5 core_clk = ~core_clk;
   // A stopped crystal gives no edges, so the prescaler cannot creep meanwhile.
   always #3 oscIn = (oscRunEn === 1'b0) ? oscIn : ~oscIn;
   always @(posedge oscIn) oscCount++;
   assign sdaLine = (sdaOe ? sdaOut : 1'b1) & sdaRel;
   assign sysRstLine = sysRstOe ? sysRstOut : 1'b1;

   brtc_top #(.DEV_ID(DEV_ID), .TICK_DIV(TICK_DIV), .RELEASE_CYC(RELEASE_CYC),
      .OSC_START_CYC(OSC_START_CYC)) i_brtc_top (.core_clk(core_clk), .rst_n(rst_n), .oscIn(oscIn),
      .oscRunEn(oscRunEn), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .vccBelowFailThreshold(vccBelowFailThreshold), .vccBelowBackupSupply(vccBelowBackupSupply),
      .onBackupSupply(onBackupSupply), .sysRstOut(sysRstOut), .sysRstOe(sysRstOe),
      .chargerCfg(chargerCfg), .chargerEnable(chargerEnable));
   brtc_i2c_master i_brtc_i2c_master (.core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaRel(sdaRel));

   // -------------------------------------------------------------------------
   // Checks and bus access
   // -------------------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude

   task automatic checkEq(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : checkEq

   task automatic checkIn(input string what, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] seen);
      checked++;
      if ((seen >= lo && seen <= hi) !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %s expected %0d to %0d seen %0d", what, lo, hi, seen);
      end
   endtask : checkIn

   task automatic regWrite(input logic [7:0] ptr, input logic [7:0] d[$], output logic nack);
      logic a;
      i_brtc_i2c_master.start();
      i_brtc_i2c_master.sendByte({DEV_ID, 1'b0}, nack);
      i_brtc_i2c_master.sendByte(ptr, a);
      nack |= a;
      foreach (d[i]) begin
         i_brtc_i2c_master.sendByte(d[i], a);
         nack |= a;
      end
      i_brtc_i2c_master.stop();
   endtask : regWrite

   task automatic regRead(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
      logic a;
      logic [7:0] b;
      q = {};
      i_brtc_i2c_master.start();
      i_brtc_i2c_master.sendByte({DEV_ID, 1'b0}, a);
      i_brtc_i2c_master.sendByte(ptr, a);
      i_brtc_i2c_master.start();
      i_brtc_i2c_master.sendByte({DEV_ID, 1'b1}, a);
      for (int i = 0; i < n; i++) begin
         i_brtc_i2c_master.recvByte(i == n - 1, b);
         q.push_back(b);
      end
      i_brtc_i2c_master.stop();
   endtask : regRead

   task automatic readCount(output logic [31:0] v);
      logic [7:0] q[$];
      regRead(8'h00, 4, q);
      v = {q[3], q[2], q[1], q[0]};
   endtask : readCount

   task automatic waitRelease(input int lo);
      int n;
      n = 0;
      while (sysRstLine !== 1'b1 && n < 1000) begin
         @(negedge core_clk);
         n++;
      end
      checkIn("release delay", lo, lo + 8, n);
   endtask : waitRelease

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic testMap();
      logic nack;
      logic [7:0] q[$];
      logic [7:0] exp[$];
      regRead(8'h04, 2, q);
      checkEq("ctrl reset", 32'h0, q[0]);
      checkEq("charger reset", 32'h0, q[1]);
      checkEq("charger off", 32'h0, chargerEnable);
      regWrite(8'h04, {8'hFF, 8'hA5, 8'hF8, 8'hFF, 8'hFF, 8'hFF}, nack);
      checkEq("write ack", 32'h0, nack);
      exp = {8'hF8, 8'hFF, 8'hFF, 8'hFF, 8'h80, 8'hA5, 8'hF8};
      regRead(8'h00, 7, q);
      foreach (exp[i]) begin
         checkEq("register byte", exp[i], q[i]);
      end
      checkEq("charger cfg", 32'hA5, chargerCfg);
   endtask : testMap

   // Both ends of the span are taken after equal bus traffic, so the offsets cancel.
   task automatic testCounting();
      logic nack;
      logic [31:0] v, w;
      int t0, t1;
      regWrite(8'h04, {8'h00}, nack);
      t0 = oscCount;
      repeat (20 * TICK_DIV) @(posedge oscIn);
      @(negedge core_clk);
      regWrite(8'h04, {8'h80}, nack);
      t1 = oscCount;
      readCount(v);
      checkIn("count advance", (t1 - t0) / TICK_DIV - 1, (t1 - t0) / TICK_DIV + 1, v - 32'hFFFF_FFF8);
      repeat (4 * TICK_DIV) @(posedge oscIn);
      @(negedge core_clk);
      readCount(w);
      checkEq("count frozen", v, w);
   endtask : testCounting

   task automatic testSupply();
      logic nack;
      logic [7:0] q[$];
      logic [31:0] v0, v1;
      int t0;
      vccBelowFailThreshold = 1'b1;
      repeat (4) @(negedge core_clk);
      checkEq("reset on fail", 32'h0, sysRstLine);
      regWrite(8'h05, {8'h00}, nack);
      checkEq("nack on fail", 32'h1, nack);
      vccBelowBackupSupply = 1'b1;
      repeat (4) @(negedge core_clk);
      checkEq("on backup", 32'h1, onBackupSupply);
      checkEq("osc standby", 32'h0, oscRunEn);
      vccBelowBackupSupply = 1'b0;
      repeat (4) @(negedge core_clk);
      checkEq("off backup", 32'h0, onBackupSupply);
      checkEq("osc on primary", 32'h1, oscRunEn);
      vccBelowFailThreshold = 1'b0;
      waitRelease(RELEASE_CYC + OSC_START_CYC);
      regRead(8'h05, 1, q);
      checkEq("write dropped", 32'hA5, q[0]);
      regWrite(8'h04, {8'h00}, nack);
      readCount(v0);
      t0 = oscCount;
      vccBelowFailThreshold = 1'b1;
      vccBelowBackupSupply = 1'b1;
      repeat (400) @(negedge core_clk);
      checkEq("osc on backup", 32'h1, oscRunEn);
      vccBelowBackupSupply = 1'b0;
      vccBelowFailThreshold = 1'b0;
      waitRelease(RELEASE_CYC);
      readCount(v1);
      checkIn("backup count", (oscCount - t0) / TICK_DIV - 1, (oscCount - t0) / TICK_DIV + 1, v1 - v0);
   endtask : testSupply

   task automatic testCharger();
      logic nack;
      logic [7:0] pats[$];
      logic [0:7] ens = 8'b1110_0000;
      pats = {8'hA5, 8'hA6, 8'hAB, 8'hA0, 8'hAD, 8'hA1, 8'h55, 8'h00};
      foreach (pats[i]) begin
         regWrite(8'h05, {pats[i]}, nack);
         checkEq("charger cfg", pats[i], chargerCfg);
         checkEq("charger enable", ens[i], chargerEnable);
      end
      i_brtc_i2c_master.start();
      i_brtc_i2c_master.sendByte({DEV_ID ^ 7'h01, 1'b0}, nack);
      i_brtc_i2c_master.stop();
      checkEq("foreign id", 32'h1, nack);
   endtask : testCharger

   initial begin
      repeat (6) @(negedge core_clk);
      checkEq("reset held", 32'h0, sysRstLine);
      rst_n = 1'b1;
      waitRelease(RELEASE_CYC);
      testMap();
      testCounting();
      testSupply();
      testCharger();
      conclude();
   end

   initial begin
      #1500000;
      n_fail++;
      conclude();
   end
endmodule : tb
